// [smc_pkg.sv]
// shared constants, types and mode table of the sleep-mode controller
package smc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SMC_IEN_CMD_OFF = 8'hc0;
  localparam logic [7:0] SMC_IDIS_CMD_OFF = 8'hc4;
  localparam logic [7:0] SMC_IEN_STATE_OFF = 8'hc8;
  localparam logic [7:0] SMC_IRQ_STATUS_OFF = 8'hd0;
  localparam logic [7:0] SMC_CTRL_OFF = 8'hd4;
  localparam logic [7:0] SMC_SLEEP_STATE_OFF = 8'hd8;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SMC_ACCESS_ERROR_BIT = 31;
  localparam int SMC_CLOCK_READY_BIT = 5;
  localparam int SMC_CLOCK_FAILURE_BIT = 0;
  localparam logic [31:0] SMC_IRQ_IMPL_MASK = 32'h8000_0021;
  localparam logic [31:0] SMC_IEN_STATE_RST = 32'h0000_0000;
  localparam logic [31:0] SMC_IRQ_STATUS_RST = 32'h0000_0000;
  localparam int SMC_CTRL_XTAL_BIT = 0;
  localparam logic SMC_CTRL_XTAL_RST = 1'b0;
  localparam logic [2:0] SMC_MAX_MODE = 3'h6;

  // axi responses
  localparam logic [1:0] SMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SMC_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing: clock-source restart wait on wake from deep modes
  // ----------------------------------------------------------------
  localparam int SMC_CLK_MHZ = 250;
  localparam int SMC_SRC_START_NS = 1000;
  localparam int SMC_SRC_START_CYC = (SMC_SRC_START_NS * SMC_CLK_MHZ + 999) / 1000;
  localparam logic [2:0] SMC_DEEP_MODE = 3'h3;

  // regulator level
  typedef enum logic [1:0] {
    SMC_VREG_NORMAL = 2'h0,
    SMC_VREG_LOW = 2'h1,
    SMC_VREG_OFF = 2'h2
  } smc_vreg_t;

  // enables of every domain, source and analog block
  typedef struct packed {
    logic cpu_clk;
    logic hsb_clk;
    logic pb_generic_clocks;
    logic sources;
    logic cycle_timer;
    logic slow_xtal;
    logic sys_rc;
    logic async_wdt;
    logic bandgap_bod;
    smc_vreg_t vreg;
  } smc_pwr_t;

  // interrupt events of the block
  typedef struct packed {
    logic access_error;
    logic clock_ready;
    logic clock_failure;
  } smc_evt_t;

  // power table: asleep low gives the run setting
  function automatic smc_pwr_t smc_pwr_f(input logic [2:0] mode, input logic asleep,
                                         input logic xtal);
    smc_pwr_t p;
    p.cpu_clk = !asleep;
    p.hsb_clk = !asleep || (mode == 3'h0);
    p.pb_generic_clocks = !asleep || (mode <= 3'h1);
    p.sources = !asleep || (mode <= 3'h2);
    p.cycle_timer = !asleep || (mode <= 3'h2);
    p.slow_xtal = xtal;
    p.sys_rc = !asleep || (mode <= 3'h4);
    p.async_wdt = !asleep || (mode <= 3'h3);
    p.bandgap_bod = !asleep || (mode <= 3'h3);
    if (!asleep || mode <= 3'h2)
    begin
      p.vreg = SMC_VREG_NORMAL;
    end
    else if (mode <= 3'h5)
    begin
      p.vreg = SMC_VREG_LOW;
    end
    else
    begin
      p.vreg = SMC_VREG_OFF;
    end
    return p;
  endfunction

endpackage

// [smc_sleep_ctrl.sv]
// sleep-mode controller with axi4-lite register slave and interrupt logic
//
// Functional notes
// R1: sleep instruction stops cpu and every domain of the mode, ignoring masks.
// R2: an interrupt request wakes the device and restarts cpu and halted modules.
// R3: interrupts from modules unclocked in the current mode cannot wake.
// R4: cpu gives mode index 0 to 6 with the sleep instruction.
// R5: mode 0 stops only the cpu clock; regulator normal.
// R6: mode 1 stops cpu and high-speed bus domain; regulator normal.
// R7: mode 2 stops all synchronous domains; sources, cycle timer, bandgap run.
// R8: mode 3 also stops sources and cycle timer; regulator low power.
// R9: mode 4 also turns off bandgap and brownout detector.
// R10: mode 5 also stops the system rc oscillator.
// R11: mode 6 also switches the regulator off; 3.3V supply with 1.8V io only.
// R12: slow crystal runs through sleep only when software enabled it before.
// R13: regulator level follows the selected sleep mode.
// R14: enable-state register reads 1 for enabled interrupts; resets to zero.
// R15: writing one to enable command sets the matching mask bit.
// R16: writing one to disable command clears the matching mask bit.
// R17: access error bit 31, clock ready bit 5, clock failure bit 0.
// R18: on wake restore sources, then domains, then release the cpu.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int AXI_AW = 8,
  parameter int START_CYC = SMC_SRC_START_CYC
)
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // sleep instruction from the cpu
  input wire logic sleep_req_i,
  input wire logic [2:0] sleep_mode_i,
  // wake requests
  input wire logic wake_pb_irq_i,
  input wire logic wake_async_irq_i,
  // clock events
  input wire logic clock_ready_evt_i,
  input wire logic clock_failure_evt_i,
  // axi4-lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power control and status
  output smc_pwr_t pwr_o,
  output logic sleeping_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word-aligned address match
  function automatic logic hit_f(input logic [AXI_AW-1:0] addr, input logic [7:0] off);
    return addr[AXI_AW-1:2] == off[AXI_AW-1:2];
  endfunction

  // byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask_f(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_SRC,
    ST_WAKE_DOM
  } smc_state_t;

  localparam logic [11:0] START_LAST = 12'(START_CYC - 1);

  smc_state_t state_ff;
  smc_pwr_t pwr_ff;
  logic [2:0] mode_ff;
  logic [11:0] wait_ff;
  logic [31:0] ien_ff;
  logic [31:0] status_ff;
  logic [31:0] nxt_status;
  logic xtal_en_ff;
  logic irq_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [AXI_AW-1:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_fire;
  logic wr_mapped;
  logic rd_fire;
  logic rd_mapped;
  logic [31:0] wbits;
  logic wake_hit;
  smc_evt_t evt;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  // write happens once both address and data are held and no response waits
  assign wr_fire = ce_i && aw_held_ff && w_held_ff && !bvalid_ff;
  assign wbits = wdata_ff & strb_mask_f(wstrb_ff);
  assign wr_mapped = hit_f(waddr_ff, SMC_IEN_CMD_OFF) || hit_f(waddr_ff, SMC_IDIS_CMD_OFF)
                  || hit_f(waddr_ff, SMC_IEN_STATE_OFF) || hit_f(waddr_ff, SMC_IRQ_STATUS_OFF)
                  || hit_f(waddr_ff, SMC_CTRL_OFF) || hit_f(waddr_ff, SMC_SLEEP_STATE_OFF);

  // address and data latches, taken in either order
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      waddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (ce_i)
    begin
      if (s_axi_awvalid && !aw_held_ff)
      begin
        aw_held_ff <= 1'b1;
        waddr_ff <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_ff)
      begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= SMC_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (wr_fire)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign rd_fire = ce_i && s_axi_arvalid && arready_ff;
  assign rd_mapped = hit_f(s_axi_araddr, SMC_IEN_CMD_OFF) || hit_f(s_axi_araddr, SMC_IDIS_CMD_OFF)
                  || hit_f(s_axi_araddr, SMC_IEN_STATE_OFF)
                  || hit_f(s_axi_araddr, SMC_IRQ_STATUS_OFF)
                  || hit_f(s_axi_araddr, SMC_CTRL_OFF)
                  || hit_f(s_axi_araddr, SMC_SLEEP_STATE_OFF);

  // read data mux; command registers read as zero
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= SMC_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (rd_fire)
      begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rresp_ff <= rd_mapped ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
        rdata_ff <= 32'h0000_0000;
        // R14: enable state readback
        if (hit_f(s_axi_araddr, SMC_IEN_STATE_OFF))
        begin
          rdata_ff <= ien_ff;
        end
        else if (hit_f(s_axi_araddr, SMC_IRQ_STATUS_OFF))
        begin
          rdata_ff <= status_ff;
        end
        else if (hit_f(s_axi_araddr, SMC_CTRL_OFF))
        begin
          rdata_ff[SMC_CTRL_XTAL_BIT] <= xtal_en_ff;
        end
        else if (hit_f(s_axi_araddr, SMC_SLEEP_STATE_OFF))
        begin
          rdata_ff[$bits(smc_pwr_t)-1:0] <= pwr_ff;
          rdata_ff[18:16] <= mode_ff;
          rdata_ff[24] <= (state_ff != ST_RUN);
        end
      end
      else if (rvalid_ff && s_axi_rready)
      begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt enable, status and output
  // ----------------------------------------------------------------
  // R15 R16: set and clear commands on the enable state
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ien_ff <= SMC_IEN_STATE_RST;
    end
    else if (wr_fire)
    begin
      if (hit_f(waddr_ff, SMC_IEN_CMD_OFF))
      begin
        ien_ff <= ien_ff | (wbits & SMC_IRQ_IMPL_MASK);
      end
      else if (hit_f(waddr_ff, SMC_IDIS_CMD_OFF))
      begin
        ien_ff <= ien_ff & ~wbits;
      end
    end
  end

  // an unmapped access raises the access error event
  assign evt.access_error = (wr_fire && !wr_mapped) || (rd_fire && !rd_mapped);
  assign evt.clock_ready = clock_ready_evt_i;
  assign evt.clock_failure = clock_failure_evt_i;

  // sticky status, write one to clear; a new event beats the clear
  always_comb
  begin
    nxt_status = status_ff;
    if (wr_fire && hit_f(waddr_ff, SMC_IRQ_STATUS_OFF))
    begin
      nxt_status = status_ff & ~wbits;
    end
    // R17: event bit positions
    if (evt.access_error)
    begin
      nxt_status[SMC_ACCESS_ERROR_BIT] = 1'b1;
    end
    if (evt.clock_ready)
    begin
      nxt_status[SMC_CLOCK_READY_BIT] = 1'b1;
    end
    if (evt.clock_failure)
    begin
      nxt_status[SMC_CLOCK_FAILURE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      status_ff <= SMC_IRQ_STATUS_RST;
      irq_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      status_ff <= nxt_status & SMC_IRQ_IMPL_MASK;
      irq_ff <= |(status_ff & ien_ff); // one cycle behind status
    end
  end

  // R12: software enable of the slow crystal, taken into sleep as it stands
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      xtal_en_ff <= SMC_CTRL_XTAL_RST;
    end
    else if (wr_fire && hit_f(waddr_ff, SMC_CTRL_OFF) && wstrb_ff[0])
    begin
      xtal_en_ff <= wdata_ff[SMC_CTRL_XTAL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // sleep sequencer
  // ----------------------------------------------------------------
  // R3: peripheral and own interrupts only wake while their domain is clocked
  assign wake_hit = wake_async_irq_i || (pwr_ff.pb_generic_clocks && (wake_pb_irq_i || irq_ff));

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_ff <= ST_RUN;
      mode_ff <= 3'h0;
      wait_ff <= 12'h000;
      pwr_ff <= smc_pwr_f(3'h0, 1'b0, SMC_CTRL_XTAL_RST);
    end
    else if (ce_i)
    begin
      case (state_ff)
        ST_RUN:
        begin
          pwr_ff <= smc_pwr_f(3'h0, 1'b0, xtal_en_ff);
          // R4: indices above six are not a sleep mode and are ignored
          if (sleep_req_i && sleep_mode_i <= SMC_MAX_MODE)
          begin
            // R1 R5 R6 R7 R8 R9 R10 R11 R13: apply the mode table, masks ignored
            pwr_ff <= smc_pwr_f(sleep_mode_i, 1'b1, xtal_en_ff);
            mode_ff <= sleep_mode_i;
            state_ff <= ST_SLEEP;
          end
        end
        ST_SLEEP:
        begin
          // R2: interrupt starts the wake sequence
          if (wake_hit)
          begin
            // R18: sources, bandgap and regulator come back first
            pwr_ff.sources <= 1'b1;
            pwr_ff.cycle_timer <= 1'b1;
            pwr_ff.sys_rc <= 1'b1;
            pwr_ff.async_wdt <= 1'b1;
            pwr_ff.bandgap_bod <= 1'b1;
            pwr_ff.vreg <= SMC_VREG_NORMAL;
            wait_ff <= (mode_ff >= SMC_DEEP_MODE) ? START_LAST : 12'h000;
            state_ff <= ST_WAKE_SRC;
          end
        end
        ST_WAKE_SRC:
        begin
          // R18: domains after the sources have settled
          if (wait_ff == 12'h000)
          begin
            pwr_ff.hsb_clk <= 1'b1;
            pwr_ff.pb_generic_clocks <= 1'b1;
            state_ff <= ST_WAKE_DOM;
          end
          else
          begin
            wait_ff <= wait_ff - 12'h001;
          end
        end
        ST_WAKE_DOM:
        begin
          // R18: cpu released last
          pwr_ff <= smc_pwr_f(3'h0, 1'b0, xtal_en_ff);
          state_ff <= ST_RUN;
        end
        default:
        begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign pwr_o = pwr_ff;
  assign sleeping_o = !pwr_ff.cpu_clk;
  assign irq_o = irq_ff;

endmodule

// [smc_sleep_ctrl_assertions.sv]
// concurrent checks on the sleep-mode controller ports
`timescale 1ns/1ps
module smc_sleep_ctrl_assertions
  import smc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic sleep_req_i,
  input wire logic [2:0] sleep_mode_i,
  input wire logic wake_async_irq_i,
  input wire smc_pwr_t pwr_o,
  input wire logic sleeping_o
);
  // ------------------------------------------------------------
  // sleep entry, mode table and wake
  // ------------------------------------------------------------
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  // request that must be taken; a waking core still reads as sleeping
  logic take;
  assign take = sleep_req_i && ce_i && !sleeping_o && (sleep_mode_i <= SMC_MAX_MODE);

  a_sleep_take: assert property (take |=> sleeping_o && !pwr_o.cpu_clk)
    else $error("sleep request not taken");
  a_idle_mode: assert property (take && sleep_mode_i == 3'h0 |=> pwr_o.hsb_clk &&
    pwr_o.pb_generic_clocks && pwr_o.vreg == SMC_VREG_NORMAL) else $error("idle mode wrong");
  a_frozen_mode: assert property (take && sleep_mode_i == 3'h1 |=> !pwr_o.hsb_clk &&
    pwr_o.pb_generic_clocks && pwr_o.sources) else $error("frozen mode wrong");
  a_standby_mode: assert property (take && sleep_mode_i == 3'h2 |=> !pwr_o.pb_generic_clocks &&
    pwr_o.sources && pwr_o.bandgap_bod) else $error("standby mode wrong");
  a_shutdown_mode: assert property (take && sleep_mode_i == 3'h6 |=>
    pwr_o.vreg == SMC_VREG_OFF && !pwr_o.sys_rc && !pwr_o.bandgap_bod)
    else $error("shutdown mode wrong");
  a_async_wake: assert property (sleeping_o && wake_async_irq_i && ce_i |->
    ##[1:300] !sleeping_o) else $error("no wake from interrupt");
  a_cpu_last: assert property ($rose(pwr_o.cpu_clk) |-> pwr_o.sources &&
    pwr_o.hsb_clk && $past(pwr_o.pb_generic_clocks)) else $error("cpu released too early");
  a_deep_hold: assert property (sleeping_o && !pwr_o.sources && !wake_async_irq_i
    |=> $stable(pwr_o)) else $error("deep sleep left without wake source");
endmodule

bind smc_sleep_ctrl smc_sleep_ctrl_assertions i_chk (
  .clock_i,
  .rst_b_i,
  .ce_i,
  .sleep_req_i,
  .sleep_mode_i,
  .wake_async_irq_i,
  .pwr_o,
  .sleeping_o
);

// [smc_cpu_model.sv]
// cpu core model that issues the sleep instruction and its mode operand
`timescale 1ns/1ps
module smc_cpu_model
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic go_i,
  input wire logic [2:0] mode_i,
  output logic sleep_req_o,
  output logic [2:0] sleep_mode_o
);
  logic req_ff;
  logic [2:0] mode_ff;

  // one-cycle instruction; operand toggles when idle so stale values are not trusted
  // mode operand
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      req_ff <= 1'b0;
      mode_ff <= 3'h0;
    end
    else
    begin
      req_ff <= go_i;
      mode_ff <= go_i ? mode_i : ~mode_ff;
    end
  end
  assign sleep_req_o = req_ff;
  assign sleep_mode_o = mode_ff;
endmodule

// [test_sleep_mode_controller.sv]
// self-checking testbench of the sleep-mode controller
`timescale 1ns/1ps
module test_sleep_mode_controller
  import smc_pkg::*;
;
  logic clock_i, rst_b_i, ce_i, go, wake_pb, wake_async, rdy_evt, fail_evt;
  logic sleep_req, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sleeping, irq;
  logic [2:0] cmd_mode, sleep_mode;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  smc_pwr_t pwr;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  // short source restart wait so the deep-mode wake stays quick in the bench
  localparam int START = 4;

  smc_cpu_model i_cpu (.clock_i(clock_i), .rst_b_i(rst_b_i), .go_i(go), .mode_i(cmd_mode),
    .sleep_req_o(sleep_req), .sleep_mode_o(sleep_mode));
  smc_sleep_ctrl #(.START_CYC(START)) i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .sleep_req_i(sleep_req), .sleep_mode_i(sleep_mode), .wake_pb_irq_i(wake_pb),
    .wake_async_irq_i(wake_async), .clock_ready_evt_i(rdy_evt),
    .clock_failure_evt_i(fail_evt), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pwr_o(pwr), .sleeping_o(sleeping), .irq_o(irq));

  // ------------------------------------------------------------
  // clock, timeout and shared tasks
  // ------------------------------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // hang guard, well above the expected run length
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report;
    end
  end

  task final_report;
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // write both channels together, release each as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input string n);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    chk(n, rdata, ed);
    chk("rresp", rresp, SMC_RESP_OKAY);
  endtask

  task automatic issue(input logic [2:0] m);
    @(posedge clock_i);
    go <= 1'b1;
    cmd_mode <= m;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic irq_case(input int b);
    logic [31:0] m;
    m = 32'h1 << b;
    for (int en = 1; en >= 0; en--)
    begin
      wr(en ? SMC_IEN_CMD_OFF : SMC_IDIS_CMD_OFF, m, SMC_RESP_OKAY);
      if (b == 31)
        wr(8'h40, 32'h0, SMC_RESP_SLVERR);
      else
      begin
        @(posedge clock_i);
        rdy_evt <= (b == 5);
        fail_evt <= (b == 0);
        @(posedge clock_i);
        rdy_evt <= 1'b0;
        fail_evt <= 1'b0;
      end
      repeat (3) @(posedge clock_i);
      chk("irq gated", irq, en);
      rd(SMC_IRQ_STATUS_OFF, m, "status");
      wr(SMC_IRQ_STATUS_OFF, m, SMC_RESP_OKAY);
      repeat (3) @(posedge clock_i);
      chk("irq cleared", irq, 1'b0);
    end
  endtask

  task automatic sleep_case(input logic [2:0] m);
    int n;
    smc_pwr_t e;
    smc_pwr_t r;
    wr(SMC_CTRL_OFF, {31'h0, m[0]}, SMC_RESP_OKAY);
    e = '{1'b0, m == 3'h0, m <= 3'h1, m <= 3'h2, m <= 3'h2, m[0], m <= 3'h4, m <= 3'h3,
      m <= 3'h3, (m <= 3'h2) ? SMC_VREG_NORMAL : (m <= 3'h5 ? SMC_VREG_LOW : SMC_VREG_OFF)};
    r = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, m[0], 1'b1, 1'b1, 1'b1, SMC_VREG_NORMAL};
    issue(m);
    chk("asleep pwr", pwr, e);
    wake_pb <= 1'b1;
    repeat (10) @(posedge clock_i);
    chk("pb wake", sleeping, m > 3'h1);
    wake_async <= 1'b1;
    // at least one edge passes so the wake request is never raised and dropped at once
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (n < 300 && sleeping);
    wake_pb <= 1'b0;
    wake_async <= 1'b0;
    chk("woken pwr", pwr, r);
    chk("wake cycles", n, (m <= 3'h1) ? 1 : ((m == 3'h2) ? 4 : 3 + START));
  endtask

  // a frozen block ignores a sleep request
  task automatic ce_case;
    @(posedge clock_i);
    ce_i <= 1'b0;
    issue(3'h2);
    ce_i <= 1'b1;
    @(posedge clock_i);
    chk("frozen request", sleeping, 1'b0);
  endtask

  // main sequence: reset, registers, interrupts, every sleep mode
  initial
  begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    {go, cmd_mode, wake_pb, wake_async, rdy_evt, fail_evt} = '0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    chk("reset pwr", pwr, 11'h7dc);
    rd(SMC_IEN_STATE_OFF, 32'h0, "enable reset");
    wr(SMC_IEN_CMD_OFF, 32'hffff_ffff, SMC_RESP_OKAY);
    rd(SMC_IEN_STATE_OFF, 32'h8000_0021, "enable all");
    wr(SMC_IDIS_CMD_OFF, 32'h1, SMC_RESP_OKAY);
    wr(SMC_IDIS_CMD_OFF, 32'h0, SMC_RESP_OKAY);
    wr(SMC_IEN_CMD_OFF, 32'h0, SMC_RESP_OKAY);
    wr(SMC_IEN_STATE_OFF, 32'h0, SMC_RESP_OKAY);
    rd(SMC_IEN_STATE_OFF, 32'h8000_0020, "enable partial");
    wr(SMC_IDIS_CMD_OFF, 32'hffff_ffff, SMC_RESP_OKAY);
    rd(SMC_IEN_STATE_OFF, 32'h0, "enable none");
    irq_case(0);
    irq_case(5);
    irq_case(31);
    ce_case;
    for (int m = 0; m < 7; m++)
      sleep_case(3'(m));
    issue(3'h7);
    chk("mode seven", sleeping, 1'b0);
    final_report;
  end
endmodule
